// *** design/rfw_bank.sv ***
// Receive filter and wake control register bank
`timescale 1ns/100ps
`default_nettype none
module rfw_bank (
  input wire logic clock,
  input wire logic arst_n,
  input wire rfw_pkg::rfw_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic soft_rst,
  input wire logic pci_hard_rst_pin,
  input wire rfw_pkg::rfw_rx_check_t rx_check,
  output logic rx_decided,
  output logic rx_accept,
  input wire logic link_status_pin,
  input wire logic magic_hit,
  input wire logic [2:0] frame_hit,
  input wire logic pme_en,
  input wire logic d3cold,
  input wire logic pme_clear,
  input wire logic isolation_select_wr,
  input wire logic isolation_select_in,
  output logic isolation_select,
  output logic magic_strict,
  output logic pme_n,
  output logic inta_n,
  output logic dual_clock_gate
);

  // ****************************************
  // State
  // ****************************************
  rfw_pkg::rfw_state_t s_reg;
  rfw_pkg::rfw_state_t s_next;
  logic filt_accept;
  logic wake_hit;
  logic link_up_evt;
  logic link_down_evt;

  assign link_up_evt = s_reg.link_s2 & ~s_reg.link_prev;
  assign link_down_evt = ~s_reg.link_s2 & s_reg.link_prev;

  rfw_addr_filter rfw_addr_filter_i (
    .dest(rx_check.dest),
    .crc_index(rx_check.crc_index),
    .fctl(s_reg.fctl),
    .node(s_reg.node),
    .hash(s_reg.hash),
    .accept(filt_accept)
  );

  rfw_wake_logic rfw_wake_logic_i (
    .wctl(s_reg.wctl),
    .pme_en(pme_en),
    .link_up_evt(link_up_evt),
    .link_down_evt(link_down_evt),
    .magic_hit(magic_hit),
    .frame_hit(frame_hit),
    .good_pkt(s_reg.good),
    .wake_hit(wake_hit)
  );

  // ****************************************
  // Register images
  // ****************************************
  function automatic logic [31:0] wake_image(rfw_pkg::rfw_wake_ctl_t w);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[rfw_pkg::RFW_GATE_CLK_BIT] = w.gate_en;
    v[rfw_pkg::RFW_WAKE_ALL_BIT] = w.wake_all;
    v[rfw_pkg::RFW_CRC_SELECT_LSB +: 3] = w.crc_select;
    v[rfw_pkg::RFW_FRAME_WAKE_LSB +: 3] = w.frame_wake_en;
    v[rfw_pkg::RFW_MAGIC_STRICT_BIT] = w.magic_strict;
    v[rfw_pkg::RFW_MAGIC_WAKE_BIT] = w.magic_wake_en;
    v[rfw_pkg::RFW_LINK_UP_BIT] = w.link_up_wake_en;
    v[rfw_pkg::RFW_LINK_DOWN_BIT] = w.link_down_wake_en;
    return v;
  endfunction : wake_image

  function automatic logic [15:0] port_word(rfw_pkg::rfw_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < rfw_pkg::RFW_NODE_WORDS; i++) begin
      if (s.fctl.filter_index == 4'(i)) begin
        v = s.node[i*16 +: 16];
      end
    end
    for (int i = 0; i < rfw_pkg::RFW_HASH_WORDS; i++) begin
      if (s.fctl.filter_index == rfw_pkg::RFW_IDX_HASH_FIRST + 4'(i)) begin
        v = s.hash[i*16 +: 16];
      end
    end
    return v;
  endfunction : port_word

  function automatic logic [31:0] read_mux(rfw_pkg::rfw_state_t s,
                                           logic [7:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      rfw_pkg::RFW_FILTER_CONTROL_OFS: begin
        v[rfw_pkg::RFW_FILTER_ENABLE_BIT] = s.fctl.filter_en;
        v[rfw_pkg::RFW_ACCEPT_ALL_BCAST_BIT] = s.fctl.accept_all_broadcast;
        v[rfw_pkg::RFW_ACCEPT_ALL_MCAST_BIT] = s.fctl.accept_all_multicast;
        v[rfw_pkg::RFW_ACCEPT_ALL_PHYS_BIT] = s.fctl.accept_all_physical;
        v[rfw_pkg::RFW_FILTER_INDEX_LSB +: 4] = s.fctl.filter_index;
      end
      rfw_pkg::RFW_FILTER_DATA_PORT_OFS: begin
        v[rfw_pkg::RFW_DATA_FIELD_W-1:0] = port_word(s);
      end
      rfw_pkg::RFW_WAKE_EVENT_CONTROL_OFS: begin
        v = wake_image(s.wctl);
      end
      rfw_pkg::RFW_WAKE_FRAME_CRC_WINDOW_OFS: begin
        for (int i = 0; i < rfw_pkg::RFW_FRAMES; i++) begin
          if (s.wctl.crc_select[i]) begin
            v = v | s.crc[i];
          end
        end
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction : read_mux

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [31:0] wd;
    logic [3:0] idx;
    wd = reg_req.wdata;
    idx = s_reg.fctl.filter_index;
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.decided = 1'b0;
    s_next.accept = 1'b0;
    s_next.good = 1'b0;
    s_next.hrst_s1 = pci_hard_rst_pin;
    s_next.hrst_s2 = s_reg.hrst_s1;
    s_next.link_s1 = link_status_pin;
    s_next.link_s2 = s_reg.link_s1;
    s_next.link_prev = s_reg.link_s2;
    if (reg_req.wr) begin
      case (reg_req.addr)
        rfw_pkg::RFW_FILTER_CONTROL_OFS: begin
          s_next.fctl.filter_en = wd[rfw_pkg::RFW_FILTER_ENABLE_BIT];
          s_next.fctl.accept_all_broadcast =
            wd[rfw_pkg::RFW_ACCEPT_ALL_BCAST_BIT];
          s_next.fctl.accept_all_multicast =
            wd[rfw_pkg::RFW_ACCEPT_ALL_MCAST_BIT];
          s_next.fctl.accept_all_physical =
            wd[rfw_pkg::RFW_ACCEPT_ALL_PHYS_BIT];
          s_next.fctl.filter_index = wd[rfw_pkg::RFW_FILTER_INDEX_LSB +: 4];
        end
        rfw_pkg::RFW_FILTER_DATA_PORT_OFS: begin
          // Node words then hash words; reserved codes drop the write
          if (idx <= rfw_pkg::RFW_IDX_NODE_LAST) begin
            s_next.node[idx*16 +: 16] = wd[15:0];
          end else if (idx >= rfw_pkg::RFW_IDX_HASH_FIRST &&
                       idx <= rfw_pkg::RFW_IDX_HASH_LAST) begin
            s_next.hash[(idx - rfw_pkg::RFW_IDX_HASH_FIRST)*16 +: 16] =
              wd[15:0];
          end
        end
        rfw_pkg::RFW_WAKE_EVENT_CONTROL_OFS: begin
          s_next.wctl.gate_en = wd[rfw_pkg::RFW_GATE_CLK_BIT];
          s_next.wctl.wake_all = wd[rfw_pkg::RFW_WAKE_ALL_BIT];
          s_next.wctl.crc_select = wd[rfw_pkg::RFW_CRC_SELECT_LSB +: 3];
          s_next.wctl.frame_wake_en = wd[rfw_pkg::RFW_FRAME_WAKE_LSB +: 3];
          s_next.wctl.magic_strict = wd[rfw_pkg::RFW_MAGIC_STRICT_BIT];
          s_next.wctl.magic_wake_en = wd[rfw_pkg::RFW_MAGIC_WAKE_BIT];
          s_next.wctl.link_up_wake_en = wd[rfw_pkg::RFW_LINK_UP_BIT];
          s_next.wctl.link_down_wake_en = wd[rfw_pkg::RFW_LINK_DOWN_BIT];
        end
        rfw_pkg::RFW_WAKE_FRAME_CRC_WINDOW_OFS: begin
          for (int i = 0; i < rfw_pkg::RFW_FRAMES; i++) begin
            if (s_reg.wctl.crc_select[i]) begin
              s_next.crc[i] = wd;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_req.rd) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = read_mux(s_reg, reg_req.addr);
    end
    if (rx_check.valid) begin
      s_next.decided = 1'b1;
      s_next.accept = filt_accept;
      s_next.good = filt_accept & ~rx_check.error;
    end
    // Event set wins over clear
    if (pme_clear) begin
      s_next.pme = 1'b0;
    end
    if (wake_hit) begin
      s_next.pme = 1'b1;
    end
    s_next.gate = s_reg.wctl.gate_en & d3cold & ~pme_en;
    if (isolation_select_wr) begin
      s_next.iso = isolation_select_in;
    end
    if (soft_rst) begin
      s_next.fctl = '0;
      s_next.wctl = '0;
      s_next.crc = '0;
      s_next.rdata = 32'h0000_0000;
    end
    // Host reset only clears the read path
    if (s_reg.hrst_s2) begin
      s_next.rvalid = 1'b0;
      s_next.rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = s_reg.rdata;
  assign reg_rvalid = s_reg.rvalid;
  assign rx_decided = s_reg.decided;
  assign rx_accept = s_reg.accept;
  assign isolation_select = s_reg.iso;
  assign magic_strict = s_reg.wctl.magic_strict;
  assign pme_n = ~s_reg.pme;
  assign inta_n = ~s_reg.pme;
  assign dual_clock_gate = s_reg.gate;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  filter_off_reject_a: assert property (
    rx_check.valid && !s_reg.fctl.filter_en |=> rx_decided && !rx_accept)
    else $error("disabled filter accepted a packet");

  bcast_follow_a: assert property (
    rx_check.valid && s_reg.fctl.filter_en && (&rx_check.dest)
    |=> rx_accept == $past(s_reg.fctl.accept_all_broadcast))
    else $error("broadcast decision ignores accept-all-broadcast");

  hash_reject_a: assert property (
    rx_check.valid && s_reg.fctl.filter_en && !(&rx_check.dest) &&
    rx_check.dest[0] && !s_reg.fctl.accept_all_multicast &&
    s_reg.hash[rx_check.crc_index] |=> !rx_accept)
    else $error("multicast with set hash bit accepted");

  hash_pass_a: assert property (
    rx_check.valid && s_reg.fctl.filter_en && !(&rx_check.dest) &&
    rx_check.dest[0] && !s_reg.hash[rx_check.crc_index] |=> rx_accept)
    else $error("multicast with clear hash bit rejected");

  ucast_match_a: assert property (
    rx_check.valid && s_reg.fctl.filter_en && !rx_check.dest[0] &&
    !s_reg.fctl.accept_all_physical
    |=> rx_accept == ($past(rx_check.dest) == $past(s_reg.node)))
    else $error("unicast decision differs from node compare");

  node_octet_a: assert property (
    reg_req.wr && reg_req.addr == rfw_pkg::RFW_FILTER_DATA_PORT_OFS &&
    s_reg.fctl.filter_index == 4'h0 && !soft_rst
    |=> s_reg.node[7:0] == $past(reg_req.wdata[7:0]))
    else $error("node octet 0 not in low byte");

  port_resv_a: assert property (
    reg_req.rd && reg_req.addr == rfw_pkg::RFW_FILTER_DATA_PORT_OFS
    |=> (reg_rvalid || $past(s_reg.hrst_s2)) &&
        reg_rdata[31:16] == 16'h0000)
    else $error("data port upper half not zero");

  wake_resv_a: assert property (
    reg_req.rd && reg_req.addr == rfw_pkg::RFW_WAKE_EVENT_CONTROL_OFS
    |=> (reg_rdata & 32'h388f_f3fc) == 32'h0000_0000)
    else $error("reserved wake control bits read nonzero");

  hard_keep_a: assert property (
    s_reg.hrst_s2 && !soft_rst && !reg_req.wr |=> $stable(s_reg.wctl))
    else $error("host reset disturbed wake control");

  soft_clear_a: assert property (
    soft_rst && !isolation_select_wr
    |=> s_reg.wctl == '0 && $stable(isolation_select))
    else $error("soft reset did not clear wake control alone");

  gate_follow_a: assert property (
    s_reg.wctl.gate_en == 1'b0 |=> !dual_clock_gate)
    else $error("clock gated with gate enable clear");

  link_wake_a: assert property (
    link_down_evt && s_reg.wctl.link_down_wake_en && pme_en
    |=> !pme_n && !inta_n)
    else $error("enabled link loss gave no wake");

  no_pme_en_a: assert property (
    !pme_en && !(s_reg.wctl.wake_all && s_reg.good) && !s_reg.pme
    |=> pme_n)
    else $error("wake raised without PME enable");

  crc_steer_a: assert property (
    reg_req.wr && reg_req.addr == rfw_pkg::RFW_WAKE_FRAME_CRC_WINDOW_OFS &&
    s_reg.wctl.crc_select == 3'h4 && !soft_rst
    |=> s_reg.crc[2] == $past(reg_req.wdata) && $stable(s_reg.crc[0]))
    else $error("CRC window not steered to third frame");

  unicast_hit_c: cover property (
    rx_check.valid && !rx_check.dest[0] ##1 rx_accept);
  wake_pulse_c: cover property (pme_n ##1 !pme_n);
  gate_on_c: cover property (!dual_clock_gate ##1 dual_clock_gate);
  hash_port_c: cover property (
    reg_req.wr && s_reg.fctl.filter_index == rfw_pkg::RFW_IDX_HASH_LAST);

endmodule : rfw_bank
`default_nettype wire

// *** design/rfw_pkg.sv ***
// Shared constants and types of the receive filter and wake control bank
package rfw_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] RFW_FILTER_CONTROL_OFS = 8'h48;
  localparam logic [7:0] RFW_FILTER_DATA_PORT_OFS = 8'h4c;
  localparam logic [7:0] RFW_WAKE_EVENT_CONTROL_OFS = 8'hb0;
  localparam logic [7:0] RFW_WAKE_FRAME_CRC_WINDOW_OFS = 8'hbc;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RFW_FILTER_ENABLE_BIT = 31;
  localparam int RFW_ACCEPT_ALL_BCAST_BIT = 30;
  localparam int RFW_ACCEPT_ALL_MCAST_BIT = 29;
  localparam int RFW_ACCEPT_ALL_PHYS_BIT = 28;
  localparam int RFW_FILTER_INDEX_LSB = 16;
  localparam int RFW_DATA_FIELD_W = 16;
  localparam int RFW_GATE_CLK_BIT = 31;
  localparam int RFW_WAKE_ALL_BIT = 30;
  localparam int RFW_CRC_SELECT_LSB = 24;
  localparam int RFW_FRAME_WAKE_LSB = 20;
  localparam int RFW_MAGIC_STRICT_BIT = 11;
  localparam int RFW_MAGIC_WAKE_BIT = 10;
  localparam int RFW_LINK_UP_BIT = 1;
  localparam int RFW_LINK_DOWN_BIT = 0;

  // ****************************************
  // Filter index codes
  // ****************************************
  localparam logic [3:0] RFW_IDX_NODE_LAST = 4'h2;
  localparam logic [3:0] RFW_IDX_HASH_FIRST = 4'h4;
  localparam logic [3:0] RFW_IDX_HASH_LAST = 4'hb;
  localparam int RFW_NODE_WORDS = 3;
  localparam int RFW_HASH_WORDS = 8;
  localparam int RFW_FRAMES = 3;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rfw_reg_req_t;

  typedef struct packed {
    logic valid;
    logic error;
    logic [47:0] dest;
    logic [6:0] crc_index;
  } rfw_rx_check_t;

  typedef struct packed {
    logic filter_en;
    logic accept_all_broadcast;
    logic accept_all_multicast;
    logic accept_all_physical;
    logic [3:0] filter_index;
  } rfw_filter_ctl_t;

  typedef struct packed {
    logic gate_en;
    logic wake_all;
    logic [2:0] crc_select;
    logic [2:0] frame_wake_en;
    logic magic_strict;
    logic magic_wake_en;
    logic link_up_wake_en;
    logic link_down_wake_en;
  } rfw_wake_ctl_t;

  typedef struct packed {
    rfw_filter_ctl_t fctl;
    logic [47:0] node;
    logic [127:0] hash;
    rfw_wake_ctl_t wctl;
    logic [2:0][31:0] crc;
    logic iso;
    logic [31:0] rdata;
    logic rvalid;
    logic decided;
    logic accept;
    logic good;
    logic pme;
    logic gate;
    logic hrst_s1;
    logic hrst_s2;
    logic link_s1;
    logic link_s2;
    logic link_prev;
  } rfw_state_t;

endpackage : rfw_pkg

// *** design/rfw_addr_filter.sv ***
// Destination address qualification of a received packet
`timescale 1ns/100ps
`default_nettype none
module rfw_addr_filter (
  input wire logic [47:0] dest,
  input wire logic [6:0] crc_index,
  input wire rfw_pkg::rfw_filter_ctl_t fctl,
  input wire logic [47:0] node,
  input wire logic [127:0] hash,
  output logic accept
);
  logic bcast;
  logic mcast;

  always_comb begin
    bcast = &dest;
    mcast = dest[0];
    if (!fctl.filter_en) begin
      accept = 1'b0;
    end else if (bcast) begin
      accept = fctl.accept_all_broadcast;
    end else if (mcast) begin
      // Set hash bit rejects
      accept = fctl.accept_all_multicast | ~hash[crc_index];
    end else begin
      // Octet 0 sits in bits 7-0 of both
      accept = fctl.accept_all_physical | (dest == node);
    end
  end
endmodule : rfw_addr_filter
`default_nettype wire

// *** design/rfw_wake_logic.sv ***
// Selection of enabled wake-up events
`timescale 1ns/100ps
`default_nettype none
module rfw_wake_logic (
  input wire rfw_pkg::rfw_wake_ctl_t wctl,
  input wire logic pme_en,
  input wire logic link_up_evt,
  input wire logic link_down_evt,
  input wire logic magic_hit,
  input wire logic [2:0] frame_hit,
  input wire logic good_pkt,
  output logic wake_hit
);
  logic gated;

  always_comb begin
    gated = (|(wctl.frame_wake_en & frame_hit))
      | (wctl.magic_wake_en & magic_hit)
      | (wctl.link_up_wake_en & link_up_evt)
      | (wctl.link_down_wake_en & link_down_evt);
    wake_hit = (pme_en & gated) | (wctl.wake_all & good_pkt);
  end
endmodule : rfw_wake_logic
`default_nettype wire

// *** verification/rfw_host_model.sv ***
// Host software model issuing register accesses to the bank
`timescale 1ns/100ps
`default_nettype none
module rfw_host_model (
  input wire logic clock,
  output var rfw_pkg::rfw_reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_req = '0;
  end

  // One-cycle write strobe; data inverted once released
  task automatic write_reg(input logic [7:0] addr, input logic [31:0] data);
    @(negedge clock);
    reg_req.addr = addr;
    reg_req.wdata = data;
    reg_req.wr = 1'b1;
    @(negedge clock);
    reg_req.wr = 1'b0;
    reg_req.wdata = ~data;
  endtask : write_reg

  // Read answer must come exactly one cycle after the strobe
  task automatic read_reg(input logic [7:0] addr, output logic [31:0] data,
                          output logic ok);
    @(negedge clock);
    reg_req.addr = addr;
    reg_req.rd = 1'b1;
    @(negedge clock);
    reg_req.rd = 1'b0;
    reg_req.addr = ~addr;
    ok = reg_rvalid;
    data = reg_rdata;
  endtask : read_reg
endmodule : rfw_host_model
`default_nettype wire

// *** verification/rfw_bank_test.sv ***
// Self-checking testbench of the receive filter and wake control bank
`timescale 1ns/100ps
`default_nettype none
module rfw_bank_test;
  localparam logic [7:0] fc = rfw_pkg::RFW_FILTER_CONTROL_OFS;
  localparam logic [7:0] fd = rfw_pkg::RFW_FILTER_DATA_PORT_OFS;
  localparam logic [7:0] wk = rfw_pkg::RFW_WAKE_EVENT_CONTROL_OFS;
  localparam logic [7:0] cw = rfw_pkg::RFW_WAKE_FRAME_CRC_WINDOW_OFS;
  logic clock, arst_n, soft_rst, pci_hard_rst_pin, link_status_pin;
  logic magic_hit, pme_en, d3cold, pme_clear, iso_wr, iso_in;
  logic [2:0] frame_hit;
  rfw_pkg::rfw_reg_req_t reg_req;
  rfw_pkg::rfw_rx_check_t rx_check;
  logic [31:0] reg_rdata;
  logic reg_rvalid, rx_decided, rx_accept, iso, strict, pme_n, inta_n, gate;
  int errors, checked;

  rfw_bank rfw_bank_i (.clock(clock), .arst_n(arst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .soft_rst(soft_rst),
    .pci_hard_rst_pin(pci_hard_rst_pin), .rx_check(rx_check),
    .rx_decided(rx_decided), .rx_accept(rx_accept),
    .link_status_pin(link_status_pin), .magic_hit(magic_hit),
    .frame_hit(frame_hit), .pme_en(pme_en), .d3cold(d3cold),
    .pme_clear(pme_clear), .isolation_select_wr(iso_wr),
    .isolation_select_in(iso_in), .isolation_select(iso),
    .magic_strict(strict), .pme_n(pme_n), .inta_n(inta_n),
    .dual_clock_gate(gate));

  rfw_host_model rfw_host_model_i (.clock(clock), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rfw_host_model_i.write_reg(a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    rfw_host_model_i.read_reg(a, d, ok);
    check({31'h0, ok}, 32'h1);
    check(d, exp);
  endtask : rd

  task automatic rx(input logic [47:0] dest, input logic [6:0] crc,
                    input logic err, input logic exp);
    @(negedge clock);
    rx_check = '{valid: 1'b1, error: err, dest: dest, crc_index: crc};
    @(negedge clock);
    rx_check = '{valid: 1'b0, error: ~err, dest: ~dest, crc_index: ~crc};
    check({31'h0, rx_decided}, 32'h1);
    if (!err) check({31'h0, rx_accept}, {31'h0, exp});
  endtask : rx

  task automatic wake_chk(input logic exp);
    check({30'h0, pme_n, inta_n}, exp ? 32'h0 : 32'h3);
    pme_clear = 1'b1;
    @(negedge clock);
    pme_clear = 1'b0;
    @(negedge clock);
    check({31'h0, pme_n}, 32'h1);
  endtask : wake_chk

  task automatic fire(input logic [31:0] ctl, input logic pme, input logic m,
                      input logic [2:0] f, input logic exp);
    wr(wk, ctl);
    pme_en = pme;
    @(negedge clock);
    magic_hit = m;
    frame_hit = f;
    @(negedge clock);
    magic_hit = 1'b0;
    frame_hit = 3'h0;
    wake_chk(exp);
  endtask : fire

  task automatic link_case(input logic [31:0] ctl, input logic lvl,
                           input logic exp);
    wr(wk, ctl);
    pme_en = 1'b1;
    link_status_pin = lvl;
    repeat (6) @(negedge clock);
    wake_chk(exp);
  endtask : link_case

  task automatic gate_case(input logic g, input logic d3, input logic pme,
                           input logic exp);
    wr(wk, {g, 31'h0});
    d3cold = d3;
    pme_en = pme;
    repeat (2) @(negedge clock);
    check({31'h0, gate}, {31'h0, exp});
  endtask : gate_case

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_filter_regs;
    rd(wk, 32'h0);
    rd(8'h50, 32'h0);
    wr(fc, 32'h0);
    wr(fd, 32'hffffe000);
    wr(fc, 32'h00010000);
    wr(fd, 32'h00000706);
    wr(fc, 32'h00020000);
    wr(fd, 32'h00005528);
    wr(fc, 32'h00030000);
    wr(fd, 32'h00001234);
    rd(fd, 32'h0);
    wr(fc, 32'h00000000);
    rd(fd, 32'h0000e000);
    wr(fc, 32'h00020000);
    rd(fd, 32'h00005528);
    wr(fc, 32'h00040000);
    wr(fd, 32'h00000020);
    rd(fd, 32'h00000020);
    wr(fc, 32'h000b0000);
    wr(fd, 32'h00008000);
    rd(fd, 32'h00008000);
  endtask : t_filter_regs

  task automatic t_filter_rx;
    rx(48'h5528_0706_e000, 7'h00, 1'b0, 1'b0);
    wr(fc, 32'h80000000);
    rx(48'h5528_0706_e000, 7'h00, 1'b0, 1'b1);
    rx(48'h5428_0706_e000, 7'h00, 1'b0, 1'b0);
    rx(48'hffff_ffff_ffff, 7'h00, 1'b0, 1'b0);
    rx(48'h0000_0000_0001, 7'h05, 1'b0, 1'b0);
    rx(48'h0000_0000_0001, 7'h7f, 1'b0, 1'b0);
    rx(48'h0000_0000_0001, 7'h06, 1'b0, 1'b1);
    wr(fc, 32'hf0000000);
    rx(48'hffff_ffff_ffff, 7'h00, 1'b0, 1'b1);
    rx(48'h0000_0000_0001, 7'h05, 1'b0, 1'b1);
    rx(48'h5428_0706_e000, 7'h00, 1'b0, 1'b1);
  endtask : t_filter_rx

  task automatic t_wake_reg;
    wr(wk, 32'hffffffff);
    rd(wk, 32'hc7700c03);
    check({31'h0, strict}, 32'h1);
    wr(wk, 32'h0);
    check({31'h0, strict}, 32'h0);
    // Only one select bit at a time
    for (int i = 0; i < 3; i++) begin
      wr(wk, 32'h1 << (24 + i));
      wr(cw, 32'h11111111 * (i + 1));
    end
    for (int i = 0; i < 3; i++) begin
      wr(wk, 32'h1 << (24 + i));
      rd(cw, 32'h11111111 * (i + 1));
    end
  endtask : t_wake_reg

  task automatic t_events;
    fire(32'h400, 1'b1, 1'b1, 3'h0, 1'b1);
    fire(32'h400, 1'b0, 1'b1, 3'h0, 1'b0);
    fire(32'h000, 1'b1, 1'b1, 3'h0, 1'b0);
    for (int i = 0; i < 3; i++) begin
      fire(32'h1 << (20 + i), 1'b1, 1'b0, 3'h1 << i, 1'b1);
      fire(32'h1 << (20 + i), 1'b1, 1'b0, 3'h1 << ((i + 1) % 3), 1'b0);
      fire(32'h1 << (20 + i), 1'b0, 1'b0, 3'h1 << i, 1'b0);
    end
    link_case(32'h2, 1'b0, 1'b0);
    link_case(32'h1, 1'b1, 1'b0);
    link_case(32'h1, 1'b0, 1'b1);
    link_case(32'h2, 1'b1, 1'b1);
    wr(wk, 32'h40000000);
    pme_en = 1'b0;
    rx(48'h5528_0706_e000, 7'h00, 1'b0, 1'b1);
    @(negedge clock);
    wake_chk(1'b1);
    rx(48'h5528_0706_e000, 7'h00, 1'b1, 1'b0);
    @(negedge clock);
    wake_chk(1'b0);
  endtask : t_events

  task automatic t_resets;
    gate_case(1'b1, 1'b1, 1'b0, 1'b1);
    gate_case(1'b1, 1'b1, 1'b1, 1'b0);
    gate_case(1'b1, 1'b0, 1'b0, 1'b0);
    gate_case(1'b0, 1'b1, 1'b0, 1'b0);
    wr(wk, 32'h00000c01);
    iso_in = 1'b1;
    iso_wr = 1'b1;
    @(negedge clock);
    iso_wr = 1'b0;
    pci_hard_rst_pin = 1'b1;
    repeat (6) @(negedge clock);
    pci_hard_rst_pin = 1'b0;
    repeat (4) @(negedge clock);
    rd(wk, 32'h00000c01);
    soft_rst = 1'b1;
    @(negedge clock);
    soft_rst = 1'b0;
    rd(wk, 32'h0);
    check({31'h0, iso}, 32'h1);
  endtask : t_resets

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    #400000;
    errors++;
    results();
  end

  initial begin
    errors = 0;
    checked = 0;
    arst_n = 1'b0;
    soft_rst = 1'b0;
    pci_hard_rst_pin = 1'b0;
    link_status_pin = 1'b1;
    magic_hit = 1'b0;
    frame_hit = 3'h0;
    pme_en = 1'b0;
    d3cold = 1'b0;
    pme_clear = 1'b0;
    iso_wr = 1'b0;
    iso_in = 1'b0;
    rx_check = '0;
    repeat (12) @(negedge clock);
    arst_n = 1'b1;
    t_filter_regs();
    t_filter_rx();
    t_wake_reg();
    t_events();
    t_resets();
    results();
  end
endmodule : rfw_bank_test
`default_nettype wire
